// ---- hdl/irab_pkg.sv ----
package irab_pkg;

   // Local register offsets
   localparam logic [11:0] OFS_TARGET_ADDR  = 12'h7a0;
   localparam logic [11:0] OFS_DATA_WORD    = 12'h7a4;
   localparam logic [11:0] OFS_TIMEOUT      = 12'h7a8;
   localparam logic [11:0] OFS_REQ_CONTROL  = 12'h7ac;
   localparam logic [11:0] OFS_ERROR_STATUS = 12'h7b0;
   localparam logic [11:0] OFS_IRQ_STATUS   = 12'h7b4;
   localparam logic [11:0] OFS_IRQ_ENABLE   = 12'h7b8;

   // Control word patterns and fields
   localparam logic [31:0] CTRL_READ_PATTERN  = 32'h000100f1;
   localparam logic [31:0] CTRL_WRITE_PATTERN = 32'h000100f2;
   localparam logic [1:0]  REQ_READ           = 2'h1;
   localparam logic [1:0]  REQ_WRITE          = 2'h2;
   localparam int          CTRL_BUSY_BIT      = 12;
   localparam int          CTRL_TMO_BIT       = 13;
   localparam int          CTRL_FLT_BIT       = 14;

   // Target address fields, later variant
   localparam int          ADDR_FIELD_W       = 26;
   localparam int          ADDR_PORT_BIT      = 27;

   // Error status fields
   localparam int          ERR_TMO_BIT        = 0;
   localparam int          ERR_BUSY_BIT       = 1;
   localparam int          ERR_WRITE_BIT      = 2;
   localparam int          ERR_ADDR_LSB       = 3;
   localparam int          ERR_FAULT_BIT      = 31;
   localparam logic [31:0] ERR_CLEAR_WORD     = 32'hffffffff;

   // Variants
   localparam logic [1:0]  VAR_EARLY          = 2'h0;
   localparam logic [1:0]  VAR_MIDDLE         = 2'h1;
   localparam logic [1:0]  VAR_LATE           = 2'h2;

   // Values after reset
   localparam logic [31:0] RST_TIMEOUT        = 32'h00001000;
   localparam logic [31:0] RST_ZERO           = 32'h00000000;

   // Ranges closed to the internal port: base and size in bytes
   localparam int          NUM_EXCL           = 4;
   localparam logic [25:0] EXCL_BASE [NUM_EXCL] = '{26'h0000000, 26'h0001000,
                                                    26'h0002000, 26'h0088000};
   localparam logic [25:0] EXCL_SIZE [NUM_EXCL] = '{26'h0001000, 26'h0001000,
                                                    26'h0002000, 26'h0001000};

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [11:0] addr;
      logic [31:0] wdata;
   } irab_reg_req_t;

   typedef struct packed {
      logic        write;
      logic        port;
      logic [31:0] addr;
      logic [31:0] wdata;
   } irab_bus_req_t;

   typedef struct packed {
      logic        valid;
      logic        fault;
      logic [31:0] rdata;
   } irab_bus_rsp_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_ISSUE = 2'b01,
      ST_WAIT  = 2'b11
   } irab_state_t;

endpackage : irab_pkg

// ---- hdl/irab_timer.sv ----
`timescale 1ns/10ps
`default_nettype none

// Down counter that flags expiry of the programmed wait
module irab_timer #(
   parameter int W = 32
) (
   // Clock and reset
   input  wire logic         sys_clk_in,
   input  wire logic         sys_rst_in,
   // Control
   input  wire logic         load_in,
   input  wire logic         run_in,
   input  wire logic [W-1:0] limit_in,
   // Status
   output logic              expired_out
);
   logic [W-1:0] count_q;
   logic [W-1:0] count_d;
   logic         at_zero;

   assign at_zero     = (count_q == '0);
   assign expired_out = run_in & ~load_in & at_zero;
   assign count_d     = load_in ? limit_in :
                        (run_in & ~at_zero) ? count_q - W'(1) : count_q;

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         count_q <= '0;
      end else begin
         count_q <= count_d;
      end
   end

endmodule : irab_timer

`default_nettype wire

// ---- hdl/irab_bridge.sv ----
//Contract
//- Read pattern to control launches one read
//- Write pattern launches one write of data
//- Busy field set while outstanding; data then valid
//- Unanswered request sets control bit 13 after timeout
//- Request field: 1 read, 2 write
//- Later variant: 26-bit address, bit 27 port
//- Internal port refuses top-level unit ranges
//- Data register sends writes, captures reads
//- Timeout register sets cycles before timeout
//- Launch while busy sets command-while-busy bit
//- Error timeout on silence, fault on no target
//- Early error layout: tmo, busy, write, address
//- Middle layout: address 3-30, fault bit 31
//- Irq status bit 0 error, cleared by zero
//- Early variants: irq ack clears error register
//- Later variant: all-ones write clears error
//- Pending and enabled drives second-level line 4
//- Enabled access error reaches core line 11
`timescale 1ns/10ps
`default_nettype none

module irab_bridge
   import irab_pkg::*;
#(
   parameter logic [1:0] VARIANT = VAR_LATE
) (
   // Clock and reset
   input  wire logic          sys_clk_in,
   input  wire logic          sys_rst_in,
   // Core register port
   input  wire irab_reg_req_t reg_req_in,
   output logic [31:0]        reg_rdata_out,
   // Interconnect request
   output irab_bus_req_t      bus_req_out,
   output logic               bus_req_valid_out,
   input  wire logic          bus_req_ready_in,
   input  wire irab_bus_rsp_t bus_rsp_in,
   // Interrupts
   output logic               second_level_interrupt_out,
   output logic               core_irq_line_out
);
   logic [31:0]  addr_q;
   logic [31:0]  data_q;
   logic [31:0]  tmo_q;
   logic [31:0]  err_q;
   logic [31:0]  err_d;
   logic         istat_q;
   logic         ien_q;
   logic         ctl_tmo_q;
   logic         ctl_flt_q;
   logic         req_write_q;
   logic [31:0]  reg_rdata_q;
   irab_state_t  state_q;
   irab_state_t  state_d;

   // Register decode
   wire          wr_addr   = reg_req_in.wr & (reg_req_in.addr == OFS_TARGET_ADDR);
   wire          wr_data   = reg_req_in.wr & (reg_req_in.addr == OFS_DATA_WORD);
   wire          wr_tmo    = reg_req_in.wr & (reg_req_in.addr == OFS_TIMEOUT);
   wire          wr_ctl    = reg_req_in.wr & (reg_req_in.addr == OFS_REQ_CONTROL);
   wire          wr_err    = reg_req_in.wr & (reg_req_in.addr == OFS_ERROR_STATUS);
   wire          wr_istat  = reg_req_in.wr & (reg_req_in.addr == OFS_IRQ_STATUS);
   wire          wr_ien    = reg_req_in.wr & (reg_req_in.addr == OFS_IRQ_ENABLE);
   wire [1:0]    req_code  = reg_req_in.wdata[1:0];
   wire          cmd_valid = wr_ctl & ((req_code == REQ_READ) | (req_code == REQ_WRITE));
   wire          busy      = (state_q != ST_IDLE);
   wire          launch    = cmd_valid & ~busy;
   wire          cmd_busy  = cmd_valid & busy;

   // Port select and target address per variant
   wire          late      = (VARIANT == VAR_LATE);
   wire          port_sel  = late & addr_q[ADDR_PORT_BIT];
   wire [31:0]   tgt_addr  = late ? {6'h00, addr_q[ADDR_FIELD_W-1:0]} : addr_q;

   // Internal port refusal of top-level ranges
   logic         excl_hit;
   always_comb begin
      excl_hit = 1'b0;
      for (int i = 0; i < NUM_EXCL; i++) begin
         if ((addr_q[ADDR_FIELD_W-1:0] >= EXCL_BASE[i]) &&
             (addr_q[ADDR_FIELD_W-1:0] - EXCL_BASE[i] < EXCL_SIZE[i])) begin
            excl_hit = 1'b1;
         end
      end
   end
   wire          refused   = port_sel & excl_hit;

   // Timeout supervision
   logic         tmo_expired;
   irab_timer #(
      .W (32)
   ) u_timer (
      .sys_clk_in  (sys_clk_in),
      .sys_rst_in  (sys_rst_in),
      .load_in     (launch),
      .run_in      (busy),
      .limit_in    (tmo_q),
      .expired_out (tmo_expired)
   );

   // Completion events
   wire          rsp_ok    = (state_q == ST_WAIT) & bus_rsp_in.valid & ~bus_rsp_in.fault;
   wire          rsp_flt   = ((state_q == ST_WAIT) & bus_rsp_in.valid & bus_rsp_in.fault)
                             | ((state_q == ST_ISSUE) & refused);
   wire          tmo_evt   = tmo_expired & ~bus_rsp_in.valid & ~(state_q == ST_ISSUE & refused);
   wire          done      = rsp_ok | rsp_flt | tmo_evt;
   wire          err_evt   = rsp_flt | tmo_evt | cmd_busy;

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (launch) begin
               state_d = ST_ISSUE;
            end
         end
         ST_ISSUE: begin
            if (refused | tmo_evt) begin
               state_d = ST_IDLE;
            end else if (bus_req_ready_in) begin
               state_d = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (done) begin
               state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   // Outgoing request
   assign bus_req_valid_out = (state_q == ST_ISSUE) & ~refused;
   assign bus_req_out       = '{write: req_write_q, port: port_sel,
                                addr: tgt_addr, wdata: data_q};

   // Error word update, set wins over clear
   wire          err_clr   = late ? (wr_err & (reg_req_in.wdata == ERR_CLEAR_WORD))
                                  : (wr_istat & ~reg_req_in.wdata[0]);
   wire          flt_field = (VARIANT != VAR_EARLY);
   always_comb begin
      err_d = err_clr ? RST_ZERO : err_q;
      if (tmo_evt | rsp_flt) begin
         err_d[ERR_WRITE_BIT] = req_write_q;
         if (flt_field) begin
            err_d[30:ERR_ADDR_LSB] = tgt_addr[30:3];
         end else begin
            err_d[31:ERR_ADDR_LSB] = tgt_addr[31:3];
         end
      end
      if (tmo_evt) begin
         err_d[ERR_TMO_BIT] = 1'b1;
      end
      if (rsp_flt & flt_field) begin
         err_d[ERR_FAULT_BIT] = 1'b1;
      end
      if (cmd_busy) begin
         err_d[ERR_BUSY_BIT] = 1'b1;
      end
   end

   // Read mux
   wire [31:0]   ctl_rd    = {17'h0, ctl_flt_q, ctl_tmo_q, busy, 12'h000};
   wire [31:0]   rd_mux    =
      (reg_req_in.addr == OFS_TARGET_ADDR)  ? addr_q :
      (reg_req_in.addr == OFS_DATA_WORD)    ? data_q :
      (reg_req_in.addr == OFS_TIMEOUT)      ? tmo_q :
      (reg_req_in.addr == OFS_REQ_CONTROL)  ? ctl_rd :
      (reg_req_in.addr == OFS_ERROR_STATUS) ? err_q :
      (reg_req_in.addr == OFS_IRQ_STATUS)   ? {31'h0, istat_q} :
      (reg_req_in.addr == OFS_IRQ_ENABLE)   ? {31'h0, ien_q} : RST_ZERO;

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         state_q     <= ST_IDLE;
         addr_q      <= RST_ZERO;
         data_q      <= RST_ZERO;
         tmo_q       <= RST_TIMEOUT;
         err_q       <= RST_ZERO;
         istat_q     <= 1'b0;
         ien_q       <= 1'b0;
         ctl_tmo_q   <= 1'b0;
         ctl_flt_q   <= 1'b0;
         req_write_q <= 1'b0;
         reg_rdata_q <= RST_ZERO;
      end else begin
         state_q     <= state_d;
         err_q       <= err_d;
         if (wr_addr) begin
            addr_q <= reg_req_in.wdata;
         end
         if (rsp_ok & ~req_write_q) begin
            data_q <= bus_rsp_in.rdata;
         end else if (wr_data) begin
            data_q <= reg_req_in.wdata;
         end
         if (wr_tmo) begin
            tmo_q <= reg_req_in.wdata;
         end
         if (launch) begin
            req_write_q <= (req_code == REQ_WRITE);
         end
         if (tmo_evt) begin
            ctl_tmo_q <= 1'b1;
         end else if (launch) begin
            ctl_tmo_q <= 1'b0;
         end
         if (rsp_flt) begin
            ctl_flt_q <= 1'b1;
         end else if (launch) begin
            ctl_flt_q <= 1'b0;
         end
         if (err_evt) begin
            istat_q <= 1'b1;
         end else if (wr_istat & ~reg_req_in.wdata[0]) begin
            istat_q <= 1'b0;
         end
         if (wr_ien) begin
            ien_q <= reg_req_in.wdata[0];
         end
         if (reg_req_in.rd) begin
            reg_rdata_q <= rd_mux;
         end
      end
   end

   assign reg_rdata_out              = reg_rdata_q;
   assign second_level_interrupt_out = istat_q & ien_q;
   assign core_irq_line_out          = istat_q & ien_q;

   // Checks
   a_read_launch: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      launch & (req_code == REQ_READ) |=> bus_req_valid_out | refused ##0 !bus_req_out.write)
      else $error("read pattern did not launch a read");
   a_write_launch: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      launch & (req_code == REQ_WRITE) & ~(late & addr_q[ADDR_PORT_BIT])
      |=> bus_req_valid_out && bus_req_out.write && bus_req_out.wdata == $past(data_q))
      else $error("write pattern did not launch a write");
   a_busy_hold: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      launch |=> ctl_rd[CTRL_BUSY_BIT])
      else $error("busy field not set after launch");
   a_read_data: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      rsp_ok & ~req_write_q |=> data_q == $past(bus_rsp_in.rdata) && !busy)
      else $error("read data not captured at completion");
   a_timeout_bit: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      tmo_evt |=> ctl_tmo_q && err_q[ERR_TMO_BIT] && !busy)
      else $error("timeout not flagged");
   a_bad_code: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      wr_ctl & ((req_code == 2'h0) | (req_code == 2'h3)) & ~busy |=> !busy)
      else $error("undecoded request launched");
   a_port_refuse: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      (state_q == ST_ISSUE) & refused |-> !bus_req_valid_out ##1 err_q[ERR_FAULT_BIT] | !flt_field)
      else $error("internal port reached a closed range");
   a_cmd_busy: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      cmd_busy |=> err_q[ERR_BUSY_BIT] && istat_q)
      else $error("command while busy not flagged");
   a_single_out: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      busy & cmd_valid |=> $stable(req_write_q))
      else $error("second request taken while busy");
   a_irq_line: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      err_evt & ien_q & ~wr_ien |=> second_level_interrupt_out && core_irq_line_out)
      else $error("error interrupt not raised");

   // Routing, error layout and clearing
   a_port_route: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      bus_req_valid_out |-> bus_req_out.port == (late & addr_q[ADDR_PORT_BIT])
      && (!late || bus_req_out.addr[31:ADDR_FIELD_W] == '0))
      else $error("port select or address field wrong");
   a_req_stand: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      bus_req_valid_out & ~bus_req_ready_in & ~tmo_evt & ~wr_addr & ~wr_data
      |=> bus_req_valid_out && $stable(bus_req_out))
      else $error("request dropped or changed before acceptance");
   a_fault_flag: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      (state_q == ST_WAIT) & bus_rsp_in.valid & bus_rsp_in.fault |=> ctl_flt_q && !busy)
      else $error("fault answer not flagged");
   a_early_layout: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      (tmo_evt | rsp_flt) & ~flt_field
      |=> err_q[31:ERR_ADDR_LSB] == $past(tgt_addr[31:3])
      && err_q[ERR_WRITE_BIT] == $past(req_write_q))
      else $error("early error word layout wrong");
   a_mid_layout: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      (tmo_evt | rsp_flt) & flt_field
      |=> err_q[30:ERR_ADDR_LSB] == $past(tgt_addr[30:3])
      && (err_q[ERR_FAULT_BIT] || !$past(rsp_flt)))
      else $error("error word layout with fault bit wrong");
   a_irq_ack: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      wr_istat & ~reg_req_in.wdata[0] & ~err_evt |=> !istat_q)
      else $error("interrupt acknowledge ignored");
   a_early_clear: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      ~late & wr_istat & ~reg_req_in.wdata[0] & ~err_evt |=> err_q == RST_ZERO)
      else $error("acknowledge did not clear error word");
   a_late_clear: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      late & wr_err & (reg_req_in.wdata == ERR_CLEAR_WORD) & ~err_evt |=> err_q == RST_ZERO)
      else $error("all-ones write did not clear error word");

   c_read_done: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      launch ##[1:20] rsp_ok);
   c_timeout: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in) tmo_evt);
   c_fault: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in) rsp_flt);
   c_busy_cmd: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in) cmd_busy);
   c_refused: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      (state_q == ST_ISSUE) & refused);

endmodule : irab_bridge

`default_nettype wire

// ---- dv/irab_icn_model.sv ----
`timescale 1ns/10ps
`default_nettype none

// Interconnect stand-in: addr[25:24] 2 faults, 3 stays silent; addr[3] picks slow timing
module irab_icn_model
   import irab_pkg::*;
(
   // Clock and reset
   input  wire logic          sys_clk_in,
   input  wire logic          sys_rst_in,
   // Request side
   input  wire irab_bus_req_t bus_req_in,
   input  wire logic          bus_req_valid_in,
   output logic               bus_req_ready_out,
   // Response side
   output irab_bus_rsp_t      bus_rsp_out,
   // Observation
   output logic [7:0]         accept_cnt_out,
   output logic               last_port_out
);
   logic [31:0]   mem_q [16];
   irab_bus_req_t req_q;
   logic [3:0]    stall_q;
   logic [3:0]    lat_q;
   logic          pend_q;
   logic [31:0]   last_q;
   logic          rvalid_q;
   logic          rfault_q;

   assign bus_req_ready_out = bus_req_valid_in && (stall_q == (bus_req_in.addr[3] ? 4'h3 : 4'h0));
   // Data lines show junk outside the response cycle
   assign bus_rsp_out = '{valid: rvalid_q, fault: rfault_q, rdata: rvalid_q ? last_q : ~last_q};

   always_ff @(posedge sys_clk_in) begin
      rvalid_q <= 1'b0;
      if (sys_rst_in) begin
         stall_q        <= 4'h0;
         pend_q         <= 1'b0;
         rfault_q       <= 1'b0;
         last_q         <= 32'h0;
         accept_cnt_out <= 8'h0;
         last_port_out  <= 1'b0;
      end else if (bus_req_valid_in && !bus_req_ready_out) begin
         stall_q <= stall_q + 4'h1;
      end else if (bus_req_valid_in) begin
         stall_q        <= 4'h0;
         req_q          <= bus_req_in;
         pend_q         <= (bus_req_in.addr[25:24] != 2'h3);
         lat_q          <= bus_req_in.addr[3] ? 4'h6 : 4'h1;
         accept_cnt_out <= accept_cnt_out + 8'h1;
         last_port_out  <= bus_req_in.port;
      end else if (pend_q && lat_q != 4'h0) begin
         lat_q <= lat_q - 4'h1;
      end else if (pend_q) begin
         pend_q   <= 1'b0;
         rvalid_q <= 1'b1;
         rfault_q <= (req_q.addr[25:24] == 2'h2);
         if (req_q.write) begin
            mem_q[req_q.addr[5:2]] <= req_q.wdata;
         end else begin
            last_q <= mem_q[req_q.addr[5:2]];
         end
      end
   end
endmodule : irab_icn_model

`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none

`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
   $display("[ERR] %s expected %h seen %h", n, e, g); end end

module tb_top
   import irab_pkg::*;
;
   localparam logic [31:0] SILENT = 32'h0b000000;
   localparam logic [31:0] FA     = 32'h02000040;
   logic          sys_clk_in = 1'b0;
   logic          sys_rst_in = 1'b1;
   irab_reg_req_t req        = '0;
   irab_bus_req_t breq;
   irab_bus_rsp_t brsp;
   logic [31:0]   rdata, v;
   logic          bvalid, bready, sli, cirq, lport;
   logic [7:0]    nacc, n0;
   irab_bus_req_t breq_e;
   irab_bus_rsp_t brsp_e;
   logic [31:0]   rdata_e;
   logic          bvalid_e, bready_e;
   logic [31:0]   ta [2]  = '{32'h00000010, 32'h08100008};
   logic [31:0]   bad [2] = '{32'h000100f0, 32'h000100f3};
   int            failures = 0;
   int            cmp_count = 0;
   int            cyc = 0;
   int            t0;

   always #2 sys_clk_in = ~sys_clk_in;
   always @(posedge sys_clk_in) cyc <= cyc + 1;

   irab_bridge u_irab_bridge (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
      .reg_req_in(req), .reg_rdata_out(rdata), .bus_req_out(breq),
      .bus_req_valid_out(bvalid), .bus_req_ready_in(bready), .bus_rsp_in(brsp),
      .second_level_interrupt_out(sli), .core_irq_line_out(cirq));

   irab_icn_model u_irab_icn_model (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
      .bus_req_in(breq), .bus_req_valid_in(bvalid), .bus_req_ready_out(bready),
      .bus_rsp_out(brsp), .accept_cnt_out(nacc), .last_port_out(lport));

   // Early variant twin on the same register stream
   irab_bridge #(.VARIANT(VAR_EARLY)) u_irab_bridge_early (.sys_clk_in(sys_clk_in),
      .sys_rst_in(sys_rst_in), .reg_req_in(req), .reg_rdata_out(rdata_e),
      .bus_req_out(breq_e), .bus_req_valid_out(bvalid_e), .bus_req_ready_in(bready_e),
      .bus_rsp_in(brsp_e), .second_level_interrupt_out(), .core_irq_line_out());

   irab_icn_model u_irab_icn_model_early (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
      .bus_req_in(breq_e), .bus_req_valid_in(bvalid_e), .bus_req_ready_out(bready_e),
      .bus_rsp_out(brsp_e), .accept_cnt_out(), .last_port_out());

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk_in);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge sys_clk_in);
      req.wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      @(posedge sys_clk_in);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(posedge sys_clk_in);
      req.rd <= 1'b0;
      #1 d = rdata;
   endtask : rd

   task automatic launch(input logic [31:0] a, input logic [31:0] d, input logic [31:0] c);
      wr(OFS_TARGET_ADDR, a);
      wr(OFS_DATA_WORD, d);
      wr(OFS_REQ_CONTROL, c);
   endtask : launch

   // Polls the control word until the busy field drops
   task automatic wait_idle(output logic [31:0] c);
      int i;
      for (i = 0; i < 300; i++) begin
         rd(OFS_REQ_CONTROL, c);
         if (c[CTRL_BUSY_BIT] === 1'b0) break;
      end
      if (i == 300) begin
         failures++;
         give_verdict();
      end
   endtask : wait_idle

   initial begin
      repeat (16) @(posedge sys_clk_in);
      sys_rst_in <= 1'b0;
      for (int k = 0; k < 8; k++) begin
         rd(OFS_TARGET_ADDR + 12'(4 * k), v);
         `CHK("reset value", (k == 2) ? RST_TIMEOUT : RST_ZERO, v)
      end
      // Root port prompt, internal port slow
      foreach (ta[k]) begin
         launch(ta[k], 32'h5a000000 | k, CTRL_WRITE_PATTERN);
         if (k == 1) begin
            rd(OFS_REQ_CONTROL, v);
            `CHK("busy", 1'b1, v[CTRL_BUSY_BIT])
         end
         wait_idle(v);
         `CHK("write done", 3'h0, v[14:12])
         launch(ta[k], 32'h0, CTRL_READ_PATTERN);
         wait_idle(v);
         rd(OFS_DATA_WORD, v);
         `CHK("read data", 32'h5a000000 | k, v)
         `CHK("port", ta[k][ADDR_PORT_BIT], lport)
      end
      n0 = nacc;
      foreach (bad[k]) begin
         wr(OFS_REQ_CONTROL, bad[k]);
         rd(OFS_REQ_CONTROL, v);
         `CHK("undefined code", 1'b0, v[CTRL_BUSY_BIT])
      end
      `CHK("undefined accepts", n0, nacc)
      wr(OFS_IRQ_ENABLE, 32'h1);
      launch(FA, 32'h0, CTRL_READ_PATTERN);
      wait_idle(v);
      `CHK("fault ctrl", 1'b1, v[CTRL_FLT_BIT])
      rd(OFS_ERROR_STATUS, v);
      `CHK("fault err", {1'b1, FA[30:3], 3'b000}, v)
      `CHK("early fault err", {FA[31:3], 3'b000}, rdata_e)
      rd(OFS_IRQ_STATUS, v);
      `CHK("irq status", 1'b1, v[0])
      `CHK("second level line", 1'b1, sli)
      `CHK("core line", 1'b1, cirq)
      wr(OFS_ERROR_STATUS, ERR_CLEAR_WORD);
      rd(OFS_ERROR_STATUS, v);
      `CHK("err clear", 32'h0, v)
      wr(OFS_IRQ_STATUS, 32'h0);
      rd(OFS_IRQ_STATUS, v);
      `CHK("irq ack", 2'b00, {v[0], sli})
      rd(OFS_ERROR_STATUS, v);
      `CHK("early ack clear", 32'h0, rdata_e)
      n0 = nacc;
      launch(32'h08001000, 32'h0, CTRL_READ_PATTERN);
      wait_idle(v);
      `CHK("closed fault", 1'b1, v[CTRL_FLT_BIT])
      `CHK("closed no access", n0, nacc)
      wr(OFS_ERROR_STATUS, ERR_CLEAR_WORD);
      wr(OFS_TIMEOUT, 32'h14);
      launch(SILENT, 32'h0, CTRL_READ_PATTERN);
      t0 = cyc;
      wait_idle(v);
      `CHK("timeout ctrl", 1'b1, v[CTRL_TMO_BIT])
      `CHK("timeout wait", 1'b1, (cyc - t0) inside {[20:25]})
      rd(OFS_ERROR_STATUS, v);
      `CHK("timeout err", 1'b1, v[ERR_TMO_BIT])
      wr(OFS_ERROR_STATUS, ERR_CLEAR_WORD);
      launch(SILENT, 32'h0, CTRL_READ_PATTERN);
      wr(OFS_REQ_CONTROL, CTRL_WRITE_PATTERN);
      wait_idle(v);
      rd(OFS_ERROR_STATUS, v);
      `CHK("busy launch", 2'b11, v[1:0])
      give_verdict();
   end
endmodule : tb_top

`default_nettype wire
